/* File: verilog/asr_host_end.sv */
// Host controller end of the serial readout port, AXI4-Lite slave.
// Assumes software sets the clock source and chain level before reads.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module asr_host_end #(
  parameter int RES_W = asr_pkg::RES_BITS
) (
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic IRQ_O,
  asr_link_if.host LINK
);
  import asr_pkg::*;

  if (RES_W < 2 || RES_W > 32) begin : g_chk_w
    $error("RES_W must lie in 2..32");
  end

  localparam int CW = $clog2(RES_W + 1);

  typedef struct packed {
    logic [7:0] awa;
    logic aw_f;
    logic [31:0] wd;
    logic [3:0] ws;
    logic w_f;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] data;
    logic [1:0] istat;
    logic [1:0] imask;
    logic irq;
    asr_rd_e st;
    logic [7:0] cnt;
    logic [CW-1:0] nbit;
    logic [RES_W-1:0] sh;
    logic primed;
    logic sclk;
    logic sel_n;
    logic [2:0] conv;
    logic busy_p;
    logic flt_p;
    logic sclk_p;
  } asr_host_s;

  asr_host_s q, d;

  logic sclk_s;
  logic sdo_s;
  logic busy_s;
  logic flt_s;

  asr_sync #(
    .W(4),
    .RST(4'h2)
  ) u_sync (
    .CLK_SYS_I(CLK_SYS_I),
    .ARST_N_I(ARST_N_I),
    .CE_I(CE_I),
    .D_I({LINK.read_fault_pulse, LINK.busy, LINK.serial_result_out, LINK.serial_clk}),
    .Q_O({flt_s, busy_s, sdo_s, sclk_s})
  );

  // ----------------------------------------------------------------
  // Registers and reader
  // ----------------------------------------------------------------
  logic [31:0] m;
  logic [31:0] nw;
  logic go;
  logic take;
  logic [7:0] half;

  always_comb begin
    d = q;
    go = 1'b0;
    take = 1'b0;
    m = {{8{q.ws[3]}}, {8{q.ws[2]}}, {8{q.ws[1]}}, {8{q.ws[0]}}};
    nw = (q.ctrl & ~m) | (q.wd & m);
    half = (q.ctrl[CTRL_DIV+:8] < 8'(DIV_MIN)) ? 8'(DIV_MIN) : q.ctrl[CTRL_DIV+:8];
    d.busy_p = busy_s;
    d.flt_p = flt_s;
    d.sclk_p = sclk_s;
    if (q.conv != '0) begin
      d.conv = q.conv - 3'h1;
    end

    if (S_AXI_AWVALID_I && q.awready) begin
      d.aw_f = 1'b1;
      d.awa = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && q.wready) begin
      d.w_f = 1'b1;
      d.wd = S_AXI_WDATA_I;
      d.ws = S_AXI_WSTRB_I;
    end
    if (q.aw_f && q.w_f && !q.bvalid) begin
      d.aw_f = 1'b0;
      d.w_f = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OK;
      case (q.awa)
        OFS_CTRL: begin
          d.ctrl = nw & ~(32'h1 << CTRL_GO) & ~(32'h1 << CTRL_CONV);
          go = nw[CTRL_GO];
          if (nw[CTRL_CONV]) begin
            d.conv = 3'(CONV_LOW_CYC);
          end
        end
        OFS_ISTAT: d.istat = q.istat & ~(q.wd[1:0] & m[1:0]);
        OFS_IMASK: d.imask = (q.imask & ~m[1:0]) | (q.wd[1:0] & m[1:0]);
        OFS_STAT, OFS_DATA: d.bresp = RESP_OK;
        default: d.bresp = RESP_SLVERR;
      endcase
    end else if (q.bvalid && S_AXI_BREADY_I) begin
      d.bvalid = 1'b0;
    end
    d.awready = !d.aw_f && !d.bvalid;
    d.wready = !d.w_f && !d.bvalid;

    if (S_AXI_ARVALID_I && q.arready) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = RESP_OK;
      case (S_AXI_ARADDR_I)
        OFS_CTRL: d.rdata = q.ctrl;
        OFS_STAT: d.rdata = {29'h0, q.primed, busy_s, q.st != RD_IDLE};
        OFS_DATA: d.rdata = q.data;
        OFS_ISTAT: d.rdata = {30'h0, q.istat};
        OFS_IMASK: d.rdata = {30'h0, q.imask};
        default: begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && S_AXI_RREADY_I) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    if (q.ctrl[CTRL_AUTO] && q.busy_p && !busy_s) begin
      go = 1'b1;
    end

    // Reader: clock idles low, bit taken at each falling edge
    case (q.st)
      RD_IDLE: begin
        if (go) begin
          d.sel_n = 1'b0;
          d.nbit = '0;
          d.cnt = half;
          d.st = q.ctrl[CTRL_EXT] ? RD_LO : RD_WAIT;
        end
      end
      RD_LO: begin
        if (q.cnt == 8'h01 && q.nbit == CW'(RES_W)) begin
          d.st = RD_IDLE;
          d.sel_n = 1'b1;
        end else if (q.cnt == 8'h01) begin
          d.sclk = 1'b1;
          d.cnt = half;
          d.st = RD_HI;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      RD_HI: begin
        if (q.cnt == 8'h01) begin
          d.sclk = 1'b0;
          d.cnt = half;
          take = 1'b1;
          d.st = RD_LO;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      RD_WAIT: take = q.sclk_p && !sclk_s;
      default: d.st = RD_IDLE;
    endcase
    if (take) begin
      d.sh = {q.sh[RES_W-2:0], sdo_s};
      d.nbit = CW'(q.nbit + 1'b1);
      if (q.nbit == CW'(RES_W - 1)) begin
        // Host-made clock: select stays low one more half period, so the
        // device still sees the last falling edge while selected
        if (q.st == RD_WAIT) begin
          d.st = RD_IDLE;
          d.sel_n = 1'b1;
        end
        d.primed = q.primed || !q.ctrl[CTRL_EXT];
        // First word after reset on the device clock is discarded
        if (q.primed || q.ctrl[CTRL_EXT]) begin
          d.data = 32'(d.sh);
          d.istat[IRQ_DONE] = 1'b1;
        end
      end
    end
    if (flt_s && !q.flt_p) begin
      d.istat[IRQ_FAULT] = 1'b1;
    end
    d.irq = |(d.istat & d.imask);
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q <= '{awa: '0, aw_f: 1'b0, wd: '0, ws: '0, w_f: 1'b0, awready: 1'b1,
             wready: 1'b1, bvalid: 1'b0, bresp: '0, arready: 1'b1, rvalid: 1'b0,
             rresp: '0, rdata: '0, ctrl: CTRL_RST, data: '0, istat: '0, imask: '0,
             irq: 1'b0, st: RD_IDLE, cnt: '0, nbit: '0, sh: '0, primed: 1'b0,
             sclk: 1'b0, sel_n: 1'b1, conv: '0, busy_p: 1'b0, flt_p: 1'b0,
             sclk_p: 1'b0};
    end else if (CE_I) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY_O = q.awready;
  assign S_AXI_WREADY_O = q.wready;
  assign S_AXI_BVALID_O = q.bvalid;
  assign S_AXI_BRESP_O = q.bresp;
  assign S_AXI_ARREADY_O = q.arready;
  assign S_AXI_RVALID_O = q.rvalid;
  assign S_AXI_RRESP_O = q.rresp;
  assign S_AXI_RDATA_O = q.rdata;
  assign IRQ_O = q.irq;
  assign LINK.sclk_host = q.sclk;
  assign LINK.sclk_host_oe_n = !q.ctrl[CTRL_EXT];
  assign LINK.cs_n = q.sel_n;
  assign LINK.rd_n = q.sel_n;
  assign LINK.convert_start_n = q.conv == '0;
  assign LINK.clock_source_select = q.ctrl[CTRL_EXT];
  assign LINK.chain_or_mode_input = q.ctrl[CTRL_CHAIN];
endmodule : asr_host_end

/* File: common/asr_pkg.sv */
// Shared constants and types of the serial result readout link.
// Assumes a 200 MHz system clock on both ends of the link.
//
// Operation
// - Selected and reading during conversion: previous result out
// - Sixteen bits, MSB first, one per clock
// - Each bit valid on both clock edges
// - Host reads all bits before conversion ends
// - Unfinished read at completion pulses read fault
// - Chain input held at a fixed level
// - Host clock gated, at least 18 MHz
// - Slow host reads after busy falls
// - Host clock idles low, phase one
// - Source select low: device drives serial clock
// - Host does one dummy read after reset; the code discards only the first device-clock word
// - Slave clock ignored unless select low
// - Select or read high: outputs released
// - Source select high: external clock accepted
package asr_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RES_BITS = 16;
  localparam int CLK_HZ = 200_000_000;
  localparam int SCLK_MIN_HZ = 18_000_000;
  localparam int SCLK_HALF_CYC = CLK_HZ / (2 * SCLK_MIN_HZ);
  localparam int DIV_MIN = 4;
  localparam int FAULT_CYC = 4;
  localparam int CONV_LOW_CYC = 4;

  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0C;
  localparam logic [7:0] OFS_IMASK = 8'h10;
  localparam int CTRL_GO = 0;
  localparam int CTRL_CONV = 1;
  localparam int CTRL_EXT = 2;
  localparam int CTRL_CHAIN = 3;
  localparam int CTRL_AUTO = 4;
  localparam int CTRL_DIV = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0504;
  localparam int ST_ACTIVE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_PRIMED = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    RD_IDLE = 4'h1,
    RD_LO = 4'h2,
    RD_HI = 4'h4,
    RD_WAIT = 4'h8
  } asr_rd_e;
endpackage : asr_pkg

/* File: common/asr_link_if.sv */
// Pins between the converter readout port and its host controller.
// Assumes one end drives each enable low only while it owns the wire.
`timescale 1ns/1ps
interface asr_link_if;
  logic sclk_dev;
  logic sclk_dev_oe_n;
  logic sclk_host;
  logic sclk_host_oe_n;
  logic serial_clk;
  logic serial_result_drv;
  logic serial_result_oe_n;
  logic serial_result_out;
  logic cs_n;
  logic rd_n;
  logic convert_start_n;
  logic busy;
  logic read_fault_pulse;
  logic clock_source_select;
  logic chain_or_mode_input;

  // Undriven clock rests low, undriven data rests high
  assign serial_clk = !sclk_dev_oe_n ? sclk_dev : (!sclk_host_oe_n ? sclk_host : 1'b0);
  assign serial_result_out = !serial_result_oe_n ? serial_result_drv : 1'b1;

  modport dev (
    input serial_clk, cs_n, rd_n, convert_start_n, clock_source_select, chain_or_mode_input,
    output sclk_dev, sclk_dev_oe_n, serial_result_drv, serial_result_oe_n, busy,
    output read_fault_pulse
  );
  modport host (
    input serial_clk, serial_result_out, busy, read_fault_pulse,
    output sclk_host, sclk_host_oe_n, cs_n, rd_n, convert_start_n,
    output clock_source_select, chain_or_mode_input
  );
endinterface : asr_link_if

/* File: verilog/asr_sync.sv */
// Three-stage synchroniser for levels from outside the clock domain.
// A new level is taken only once stages two and three agree.
`timescale 1ns/1ps
module asr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic [W-1:0] D_I,
  output logic [W-1:0] Q_O
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } asr_sync_s;

  asr_sync_s q, d;

  always_comb begin
    d = q;
    d.s1 = D_I;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.val[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q <= '{s1: RST, s2: RST, s3: RST, val: RST};
    end else if (CE_I) begin
      q <= d;
    end
  end

  assign Q_O = q.val;
endmodule : asr_sync

/* File: verilog/asr_dev_end.sv */
// Converter end of the serial readout port.
// Assumes a conversion core on the user side that raises CONV_BUSY_I
// for a conversion and holds CONV_RESULT_I valid when busy falls.
`timescale 1ns/1ps
module asr_dev_end #(
  parameter int RES_W = asr_pkg::RES_BITS,
  parameter int MCLK_HALF = asr_pkg::SCLK_HALF_CYC
) (
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  asr_link_if.dev LINK,
  input wire logic CONV_BUSY_I,
  input wire logic [RES_W-1:0] CONV_RESULT_I,
  output logic CONV_START_O,
  output logic READ_FAULT_O
);
  import asr_pkg::*;

  localparam int CW = $clog2(RES_W + 1);
  localparam int FW = $clog2(FAULT_CYC + 1);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (RES_W < 2 || RES_W > 32) begin : g_chk_w
    $error("RES_W must lie in 2..32");
  end
  if (MCLK_HALF < DIV_MIN || MCLK_HALF > 255) begin : g_chk_half
    $error("MCLK_HALF must lie in DIV_MIN..255");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic [RES_W-1:0] sh;
    logic [CW-1:0] left;
    logic sclk_p;
    logic cst_p;
    logic [7:0] div;
    logic mclk;
    logic [1:0] shd;
    logic [FW-1:0] flt;
    logic sdo;
    logic sdo_oe_n;
    logic sclk_oe_n;
    logic start;
    logic fault;
  } asr_dev_s;

  asr_dev_s q, d;

  // ----------------------------------------------------------------
  // Pin inputs
  // ----------------------------------------------------------------
  logic sclk_s;
  logic cs_s;
  logic rd_s;
  logic cst_s;
  logic ext_s;

  asr_sync #(
    .W(5),
    .RST(5'h1E)
  ) u_sync (
    .CLK_SYS_I(CLK_SYS_I),
    .ARST_N_I(ARST_N_I),
    .CE_I(CE_I),
    .D_I({LINK.clock_source_select, LINK.convert_start_n, LINK.rd_n, LINK.cs_n,
          LINK.serial_clk}),
    .Q_O({ext_s, cst_s, rd_s, cs_s, sclk_s})
  );

  // ----------------------------------------------------------------
  // Shifter, clock source and fault
  // ----------------------------------------------------------------
  logic sel;
  logic shift;

  always_comb begin
    d = q;
    sel = !cs_s && !rd_s;
    // Own clock: data moves two cycles after its falling edge, so a host
    // that synchronises clock and data alike still takes the old bit
    shift = q.shd[1];
    d.busy = CONV_BUSY_I;
    d.sclk_p = sclk_s;
    d.cst_p = cst_s;
    d.start = q.cst_p && !cst_s;
    d.shd = {q.shd[0], 1'b0};

    // Own clock only while selected and bits remain; stops low
    if (!ext_s && sel && q.left != '0) begin
      if (q.div == 8'(MCLK_HALF - 1)) begin
        d.div = '0;
        d.mclk = !q.mclk;
        d.shd[0] = q.mclk;
      end else begin
        d.div = q.div + 8'h01;
      end
    end else begin
      d.div = '0;
      d.mclk = 1'b0;
    end

    // External clock counts only with select low; shift on its fall
    if (ext_s && !cs_s && q.sclk_p && !sclk_s) begin
      shift = 1'b1;
    end

    // Advancing on the falling edge keeps each bit stable across a
    // whole rising-to-falling span, so either edge may sample it
    if (shift && q.left != '0) begin
      d.sh = {q.sh[RES_W-2:0], 1'b0};
      d.left = CW'(q.left - 1'b1);
    end

    // Completion loads the new word, which is then shifted
    // out during the next conversion. Bits still owed are a fault.
    if (q.busy && !CONV_BUSY_I) begin
      d.sh = CONV_RESULT_I;
      d.left = CW'(RES_W);
      if (q.left != '0) begin
        d.flt = FW'(FAULT_CYC);
      end else if (q.flt != '0) begin
        d.flt = FW'(q.flt - 1'b1);
      end
    end else if (q.flt != '0) begin
      d.flt = FW'(q.flt - 1'b1);
    end
    // Stretched so that a host on another clock catches it
    d.fault = d.flt != '0;

    d.sdo = d.sh[RES_W-1];
    d.sdo_oe_n = !sel;
    d.sclk_oe_n = !(!ext_s && sel);
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q <= '{busy: 1'b0, sh: '0, left: '0, sclk_p: 1'b0, cst_p: 1'b1, div: '0,
             mclk: 1'b0, shd: '0, flt: '0, sdo: 1'b0, sdo_oe_n: 1'b1, sclk_oe_n: 1'b1,
             start: 1'b0, fault: 1'b0};
    end else if (CE_I) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign LINK.sclk_dev = q.mclk;
  assign LINK.sclk_dev_oe_n = q.sclk_oe_n;
  assign LINK.serial_result_drv = q.sdo;
  assign LINK.serial_result_oe_n = q.sdo_oe_n;
  assign LINK.busy = q.busy;
  assign LINK.read_fault_pulse = q.fault;
  assign CONV_START_O = q.start;
  assign READ_FAULT_O = q.fault;
endmodule : asr_dev_end

/* File: tb/asr_link_monitor.sv */
// Concurrent checks on the readout link between the two ends.
// Assumes one system clock and reset shared by both ends.
`timescale 1ns/1ps
module asr_link_monitor (
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic sclk_dev,
  input wire logic sclk_dev_oe_n,
  input wire logic serial_clk,
  input wire logic serial_result_drv,
  input wire logic serial_result_oe_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic busy,
  input wire logic read_fault_pulse,
  input wire logic clock_source_select
);
  // ----------------------------------------------------------------
  // Falling link clock edges seen within one select window
  // ----------------------------------------------------------------
  logic [4:0] falls_q;
  logic clk_q;
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      falls_q <= 5'h0;
      clk_q <= 1'b0;
    end else begin
      clk_q <= serial_clk;
      if (cs_n) begin
        falls_q <= 5'h0;
      end else if (clk_q && !serial_clk) begin
        falls_q <= falls_q + 5'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);

  // Pin inputs pass a synchroniser, so settled windows are 8 cycles
  sequence s_selected;
    (!cs_n && !rd_n) [*8];
  endsequence
  sequence s_deselected;
    cs_n [*8];
  endsequence
  sequence s_fault_hold;
    read_fault_pulse [*4] ##1 !read_fault_pulse;
  endsequence

  a_data_driven: assert property (s_selected |-> !serial_result_oe_n)
    else $error("data not driven while selected");
  a_frame_bits: assert property ($rose(cs_n) |-> falls_q == 5'd16)
    else $error("frame did not carry sixteen clock falls");
  a_bit_stable: assert property ($fell(serial_clk) && !serial_result_oe_n
    |-> serial_result_drv == $past(serial_result_drv, 2))
    else $error("data bit moved just before falling clock");
  a_fault_width: assert property ($rose(read_fault_pulse) |-> s_fault_hold)
    else $error("read fault pulse width wrong");
  a_fault_cause: assert property ($rose(read_fault_pulse)
    |-> $past(busy) || $past(busy, 2) || $past(busy, 3))
    else $error("read fault without conversion end");
  a_dev_clk_owner: assert property (!sclk_dev_oe_n
    |-> !$past(clock_source_select, 5))
    else $error("device drives clock in external mode");
  a_dev_clk_half: assert property ($rose(sclk_dev) && !sclk_dev_oe_n
    |-> sclk_dev [*5] ##1 !sclk_dev)
    else $error("device clock high time wrong");
  a_ext_no_drive: assert property (clock_source_select [*8] |-> sclk_dev_oe_n)
    else $error("device clock driven with external source");
  a_idle_data_off: assert property (s_deselected |-> serial_result_oe_n)
    else $error("data driven while deselected");
  a_idle_clk_off: assert property (s_deselected |-> sclk_dev_oe_n)
    else $error("clock driven while deselected");
endmodule : asr_link_monitor

/* File: tb/adc_slave_serial_readout_tb.sv */
// Testbench joining both readout ends, with a behavioural conversion core.
// Assumes register map and timing as set in asr_pkg.
`timescale 1ns/1ps
module adc_slave_serial_readout_tb;
  import asr_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, conv_start, read_fault;
  logic [1:0] bresp, rresp;
  logic busy_q = 1'b0, fault_d = 1'b0, start_s = 1'b0, fault_s = 1'b0;
  logic [15:0] res_q = 16'h0000, next_res = 16'h0000;
  int conv_left = 0, conv_len = 0, fault_cnt = 0, err_count = 0, total_checks = 0;

  always #2.5 clk = ~clk;

  asr_link_if link_if();
  asr_dev_end asr_dev_end_inst (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1),
    .LINK(link_if), .CONV_BUSY_I(busy_q), .CONV_RESULT_I(res_q),
    .CONV_START_O(conv_start), .READ_FAULT_O(read_fault));
  asr_host_end asr_host_end_inst (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .IRQ_O(irq), .LINK(link_if));
  asr_link_monitor asr_link_monitor_inst (.CLK_SYS_I(clk), .ARST_N_I(arst_n),
    .sclk_dev(link_if.sclk_dev), .sclk_dev_oe_n(link_if.sclk_dev_oe_n),
    .serial_clk(link_if.serial_clk), .serial_result_drv(link_if.serial_result_drv),
    .serial_result_oe_n(link_if.serial_result_oe_n), .cs_n(link_if.cs_n),
    .rd_n(link_if.rd_n), .busy(link_if.busy), .read_fault_pulse(link_if.read_fault_pulse),
    .clock_source_select(link_if.clock_source_select));

  // ----------------------------------------------------------------
  // Conversion core: busy for conv_len cycles per start pulse
  // ----------------------------------------------------------------
  // Design pulses are caught on the falling edge, clear of their launch
  always @(negedge clk) begin
    start_s <= conv_start;
    fault_s <= read_fault;
  end
  always @(posedge clk) begin
    fault_d <= fault_s;
    if (fault_s && !fault_d) fault_cnt <= fault_cnt + 1;
    if (conv_left > 0) begin
      conv_left <= conv_left - 1;
      busy_q <= (conv_left > 1);
    end else if (start_s) begin
      busy_q <= 1'b1;
      res_q <= next_res;
      conv_left <= conv_len;
    end
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, aw_hs, w_hs, b_hs;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Handshakes are judged on values settled before the edge
    while (!(aw_ok && w_ok)) begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      @(posedge clk);
      if (aw_hs) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_hs) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge clk);
      b_hs = bvalid;
      r = bresp;
      @(posedge clk);
    end while (b_hs !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hs;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      hs = arready;
      @(posedge clk);
    end while (hs !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (hs !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OK});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axi_rd(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OK});
  endtask : rd

  task automatic start_conv(input logic [31:0] ctrl, input logic [15:0] res, input int len);
    next_res = res;
    conv_len = len;
    wr(OFS_CTRL, ctrl | (32'h1 << CTRL_CONV));
    while (busy_q !== 1'b1) @(posedge clk);
  endtask : start_conv

  // Go, then wait until the reader drops its active flag
  task automatic read_word(input logic [31:0] ctrl);
    logic [31:0] v;
    wr(OFS_CTRL, ctrl | (32'h1 << CTRL_GO));
    do rd(OFS_STAT, v); while (v[ST_ACTIVE] !== 1'b0);
  endtask : read_word

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v, ctrl;
    logic [1:0] r;
    logic [15:0] res [4];
    int f0;
    res = '{16'hA5C3, 16'h8001, 16'h7FFE, 16'h0000};
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_CTRL, v);
    chk(v, CTRL_RST);
    axi_rd(8'h40, v, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(8'h44, 32'hFFFF_FFFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test registers done");
    wr(OFS_IMASK, 32'h3);
    // Host clocks at DIV 5, chain input parked high
    ctrl = 32'h0000_050C;
    f0 = 0;
    for (int i = 0; i < 4; i++) begin
      start_conv(ctrl, res[i], 400);
      if (i > 0) begin
        if (i == 1) f0 = fault_cnt;
        read_word(ctrl);
        rd(OFS_DATA, v);
        chk(v, {16'h0, res[i-1]});
        rd(OFS_ISTAT, v);
        chk(v & 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_ISTAT, 32'h3);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
      end
      while (busy_q !== 1'b0) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    chk(fault_cnt, f0);
    $display("test read during conversion done");
    start_conv(ctrl, 16'h1234, 60);
    while (busy_q !== 1'b0) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(fault_cnt, f0 + 1);
    rd(OFS_ISTAT, v);
    chk(v & 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IMASK, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_ISTAT, 32'h3);
    rd(OFS_ISTAT, v);
    chk(v, 32'h0);
    wr(OFS_IMASK, 32'h3);
    $display("test read fault done");
    // Device makes the clock; first word is the discarded warm-up read
    ctrl = 32'h0000_0508;
    start_conv(ctrl, 16'h5A0F, 400);
    read_word(ctrl);
    rd(OFS_DATA, v);
    chk(v, 32'h0000_7FFE);
    while (busy_q !== 1'b0) @(posedge clk);
    start_conv(ctrl, 16'h0F0F, 400);
    read_word(ctrl);
    rd(OFS_DATA, v);
    chk(v, 32'h0000_5A0F);
    while (busy_q !== 1'b0) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(fault_cnt, f0 + 1);
    // Host starts the read itself once busy falls; the unread word faults
    ctrl = 32'h0000_051C;
    start_conv(ctrl, 16'hC3A5, 100);
    while (busy_q !== 1'b0) @(posedge clk);
    repeat (10) @(posedge clk);
    do rd(OFS_STAT, v); while (v[ST_ACTIVE] !== 1'b0);
    rd(OFS_DATA, v);
    chk(v, 32'h0000_C3A5);
    chk(fault_cnt, f0 + 2);
    $display("test device clock and auto read done");
    report_and_stop();
  end
endmodule : adc_slave_serial_readout_tb
